/* pkg/ipsr_pkg.sv */
package ipsr_pkg;

  // Register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] IPSR_MEAS_PRIO_OFS = 8'h00;
  localparam logic [7:0] IPSR_USB_PRIO_OFS = 8'h04;
  localparam logic [7:0] IPSR_CTRL_STAT_OFS = 8'h08;
  localparam logic [7:0] IPSR_REQ_OFS = 8'h0C;
  localparam logic [7:0] IPSR_ACK_OFS = 8'h10;

  // Field positions.
  localparam int IPSR_MEAS_PRIO_LSB = 4;
  localparam int IPSR_USB_PRIO_LSB = 8;
  localparam int IPSR_IRQ_BIT = 15;
  localparam int IPSR_HOLD_BIT = 13;
  localparam int IPSR_LVL_LSB = 8;
  localparam int IPSR_VEC_LSB = 0;

  // Reset values.
  localparam logic [2:0] IPSR_MEAS_PRIO_RST = 3'h4;
  localparam logic [2:0] IPSR_USB_PRIO_RST = 3'h0;
  localparam logic IPSR_HOLD_RST = 1'b0;
  localparam logic [3:0] IPSR_LVL_RST = 4'h0;
  localparam logic [6:0] IPSR_VEC_RST = 7'h00;

  // Priority encoding and vector offset.
  localparam logic [2:0] IPSR_PRIO_OFF = 3'h0;
  localparam int IPSR_VEC_BASE = 8;

  // Vector numbers of the two sources; arbitrary, chosen for this slice.
  localparam logic [7:0] IPSR_MEAS_VEC = 8'h50;
  localparam logic [7:0] IPSR_USB_VEC = 8'h56;

  // AHB-Lite transfer type.
  localparam logic [1:0] IPSR_HTRANS_NONSEQ = 2'h2;

endpackage

/* design/ipsr_arb.sv */
`timescale 1ns/10ps
// Picks the higher of two prioritised requests; priority zero never wins.
module ipsr_arb
  import ipsr_pkg::*;
(
  // Source A
  input wire logic req_a,
  input wire logic [2:0] prio_a,
  input wire logic [6:0] id_a,
  // Source B
  input wire logic req_b,
  input wire logic [2:0] prio_b,
  input wire logic [6:0] id_b,
  // Winner
  output logic win_valid,
  output logic [2:0] win_prio,
  output logic [6:0] win_id
);
  import ipsr_pkg::*;

  logic act_a;
  logic act_b;

  assign act_a = req_a && (prio_a != IPSR_PRIO_OFF);
  assign act_b = req_b && (prio_b != IPSR_PRIO_OFF);

  always_comb
  begin
    win_valid = act_a || act_b;
    win_prio = IPSR_PRIO_OFF;
    win_id = IPSR_VEC_RST;
    if (act_a && (!act_b || prio_a >= prio_b))
    begin
      win_prio = prio_a;
      win_id = id_a;
    end
    else if (act_b)
    begin
      win_prio = prio_b;
      win_id = id_b;
    end
  end

endmodule // ipsr_arb

/* design/ipsr_regs.sv */
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/10ps
module ipsr_regs
  import ipsr_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Core side
  input wire logic [3:0] cpu_level,
  input wire logic cpu_ack,
  output logic irq_req_r,
  output logic [3:0] irq_lvl_r
);
  import ipsr_pkg::*;

  // ------------------------------------------------------------
  // Bus address phase capture
  // ------------------------------------------------------------
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] addr_r;
  logic addr_ok;

  assign addr_ok = hsel && hready && (htrans == IPSR_HTRANS_NONSEQ);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= addr_ok && hwrite;
      rd_pend_r <= addr_ok && !hwrite;
      if (addr_ok)
        addr_r <= haddr;
    end
  end

  // Zero wait states: every transfer completes OKAY in its data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Software-written fields
  // ------------------------------------------------------------
  logic [2:0] meas_prio_r;
  logic [2:0] usb_prio_r;
  logic hold_r;
  logic [1:0] req_src_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meas_prio_r <= IPSR_MEAS_PRIO_RST;
      usb_prio_r <= IPSR_USB_PRIO_RST;
      hold_r <= IPSR_HOLD_RST;
    end
    else if (wr_pend_r)
    begin
      unique case (addr_r)
        IPSR_MEAS_PRIO_OFS: meas_prio_r <= hwdata[IPSR_MEAS_PRIO_LSB +: 3];
        IPSR_USB_PRIO_OFS: usb_prio_r <= hwdata[IPSR_USB_PRIO_LSB +: 3];
        IPSR_CTRL_STAT_OFS: hold_r <= hwdata[IPSR_HOLD_BIT];
        default: ;
      endcase
    end
  end

  // Source request lines, set by software through the request word.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      req_src_r <= 2'h0;
    else if (wr_pend_r && addr_r == IPSR_REQ_OFS)
      req_src_r <= hwdata[1:0];
  end

  // ------------------------------------------------------------
  // Arbitration and acknowledge tracking
  // ------------------------------------------------------------
  logic win_valid;
  logic [2:0] win_prio;
  logic [6:0] win_id;
  logic [6:0] ack_id_r;
  logic [3:0] lvl_nxt;

  ipsr_arb u_arb (
    .req_a(req_src_r[0]),
    .prio_a(meas_prio_r),
    .id_a(7'(IPSR_MEAS_VEC - 8'(IPSR_VEC_BASE))),
    .req_b(req_src_r[1]),
    .prio_b(usb_prio_r),
    .id_b(7'(IPSR_USB_VEC - 8'(IPSR_VEC_BASE))),
    .win_valid(win_valid),
    .win_prio(win_prio),
    .win_id(win_id)
  );

  assign lvl_nxt = {1'b0, win_prio};

  // The core raises cpu_ack when it takes the offered request.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ack_id_r <= IPSR_VEC_RST;
      irq_lvl_r <= IPSR_LVL_RST;
    end
    else if (cpu_ack && win_valid)
    begin
      ack_id_r <= win_id;
      irq_lvl_r <= lvl_nxt;
    end
  end

  // Request is raised while the core runs at or above its priority, and waits while it runs below.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_req_r <= 1'b0;
    else
      irq_req_r <= win_valid && (cpu_level >= lvl_nxt);
  end

  logic [6:0] vec_view;
  assign vec_view = hold_r ? win_id : ack_id_r;

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  logic [31:0] rd_word;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (haddr)
      IPSR_MEAS_PRIO_OFS: rd_word[IPSR_MEAS_PRIO_LSB +: 3] = meas_prio_r;
      IPSR_USB_PRIO_OFS: rd_word[IPSR_USB_PRIO_LSB +: 3] = usb_prio_r;
      IPSR_CTRL_STAT_OFS:
      begin
        rd_word[IPSR_IRQ_BIT] = irq_req_r;
        rd_word[IPSR_HOLD_BIT] = hold_r;
        rd_word[IPSR_LVL_LSB +: 4] = irq_lvl_r;
        rd_word[IPSR_VEC_LSB +: 7] = vec_view;
      end
      IPSR_REQ_OFS: rd_word[1:0] = req_src_r;
      default: ;
    endcase
  end

  // The word is decoded from the address phase and registered, so it stands for the data phase.
  // A read whose address phase overlaps a write's data phase sees the value before that write.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_ok && !hwrite)
      hrdata <= rd_word;
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_MEAS_RST: assert property (@(posedge hclk)
    $rose(hresetn) |-> meas_prio_r == IPSR_MEAS_PRIO_RST)
    else $error("measurement priority reset wrong");
  AST_USB_RST: assert property (@(posedge hclk)
    $rose(hresetn) |-> usb_prio_r == IPSR_USB_PRIO_RST)
    else $error("usb priority reset wrong");
  AST_MEAS_WR: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_r && addr_r == IPSR_MEAS_PRIO_OFS |=> meas_prio_r == $past(hwdata[6:4]))
    else $error("measurement priority write lost");
  AST_USB_WR: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_r && addr_r == IPSR_USB_PRIO_OFS |=> usb_prio_r == $past(hwdata[10:8]))
    else $error("usb priority write lost");
  AST_ZERO_MASK: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_pend_r && addr_r == IPSR_MEAS_PRIO_OFS
    |-> hrdata[31:7] == 25'h0000000 && hrdata[3:0] == 4'h0)
    else $error("unimplemented bits read nonzero");
  AST_USB_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_pend_r && addr_r == IPSR_USB_PRIO_OFS
    |-> hrdata[31:11] == 21'h000000 && hrdata[7:0] == 8'h00)
    else $error("usb register spare bits nonzero");
  AST_DISABLED: assert property (@(posedge hclk) disable iff (!hresetn)
    meas_prio_r == 3'h0 && usb_prio_r == 3'h0 |-> !win_valid)
    else $error("disabled source won");
  AST_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
    win_valid && cpu_level >= lvl_nxt |=> irq_req_r)
    else $error("pending flag not raised");
  AST_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_pend_r && addr_r == IPSR_CTRL_STAT_OFS && $past(hold_r)
    |-> hrdata[IPSR_VEC_LSB +: 7] == $past(win_id))
    else $error("vector view wrong in capture mode");
  AST_RO: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_r && addr_r == IPSR_CTRL_STAT_OFS && !(cpu_ack && win_valid)
    |=> irq_lvl_r == $past(irq_lvl_r) && ack_id_r == $past(ack_id_r))
    else $error("read-only field changed by write");

endmodule // ipsr_regs

/* tb/ipsr_core_model.sv */
`timescale 1ns/10ps
// Stands in for the processor core: holds a priority level and acknowledges on command.
module ipsr_core_model
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Commands from the bench
  input wire logic [3:0] level_in,
  input wire logic ack_go,
  // Core side of the block
  output logic [3:0] cpu_level,
  output logic cpu_ack
);
  logic go_r;
  // Acknowledge is a single-cycle pulse so that a held command cannot ack twice.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      go_r <= 1'b0;
      cpu_ack <= 1'b0;
      cpu_level <= 4'h0;
    end
    else
    begin
      go_r <= ack_go;
      cpu_ack <= ack_go & ~go_r;
      cpu_level <= level_in;
    end
  end
endmodule // ipsr_core_model

/* tb/intr_priority_status_regs_tb.sv */
`timescale 1ns/10ps
module intr_priority_status_regs_tb;
  import ipsr_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [3:0] cpu_level;
  logic cpu_ack;
  logic irq_req_r;
  logic [3:0] irq_lvl_r;
  logic [3:0] level_in = 4'h0;
  logic ack_go = 1'b0;
  logic [31:0] q;
  int err_count = 0;
  int checked = 0;

  always #5 hclk = ~hclk;

  ipsr_regs dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cpu_level(cpu_level), .cpu_ack(cpu_ack), .irq_req_r(irq_req_r),
    .irq_lvl_r(irq_lvl_r));

  ipsr_core_model core_u (.hclk(hclk), .hresetn(hresetn), .level_in(level_in),
    .ack_go(ack_go), .cpu_level(cpu_level), .cpu_ack(cpu_ack));

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= IPSR_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    // The status flags are registered from the written fields, so let them settle one edge.
    if (w)
      @(posedge hclk);
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      err_count++;
      $display("FAIL %0t saw %h expected %h", $time, s, e);
    end
  endtask

  // The mask hides fields whose value the scenario does not pin down.
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q & m, e);
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic report_and_stop;
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    #20us;
    err_count++;
    report_and_stop;
  end

  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd(IPSR_MEAS_PRIO_OFS, 32'hFFFFFFFF, 32'h00000040);
    rd(IPSR_USB_PRIO_OFS, 32'hFFFFFFFF, 32'h00000000);
    rd(IPSR_CTRL_STAT_OFS, 32'hFFFFFFFF, 32'h00000000);
    xfer(1'b1, IPSR_MEAS_PRIO_OFS, 32'hFFFFFFFF);
    rd(IPSR_MEAS_PRIO_OFS, 32'hFFFFFFFF, 32'h00000070);
    xfer(1'b1, IPSR_USB_PRIO_OFS, 32'hFFFFFFFF);
    rd(IPSR_USB_PRIO_OFS, 32'hFFFFFFFF, 32'h00000700);
    xfer(1'b1, IPSR_CTRL_STAT_OFS, 32'hFFFFFFFF);
    rd(IPSR_CTRL_STAT_OFS, 32'hFFFFFFFF, 32'h00002000);
    rd(IPSR_ACK_OFS, 32'hFFFFFFFF, 32'h00000000);
    level_in <= 4'h7;
    xfer(1'b1, IPSR_MEAS_PRIO_OFS, 32'h00000050);
    xfer(1'b1, IPSR_USB_PRIO_OFS, 32'h00000300);
    xfer(1'b1, IPSR_REQ_OFS, 32'h00000003);
    rd(IPSR_CTRL_STAT_OFS, 32'hFFFFF0FF, 32'h0000A048);
    chk({31'h0, irq_req_r}, 32'h1);
    xfer(1'b1, IPSR_USB_PRIO_OFS, 32'h00000700);
    rd(IPSR_CTRL_STAT_OFS, 32'hFFFFF0FF, 32'h0000A04E);
    xfer(1'b1, IPSR_USB_PRIO_OFS, 32'h00000000);
    rd(IPSR_CTRL_STAT_OFS, 32'hFFFFF0FF, 32'h0000A048);
    xfer(1'b1, IPSR_MEAS_PRIO_OFS, 32'h00000000);
    rd(IPSR_CTRL_STAT_OFS, 32'h00008000, 32'h00000000);
    xfer(1'b1, IPSR_MEAS_PRIO_OFS, 32'h00000050);
    level_in <= 4'h0;
    ack_go <= 1'b1;
    repeat (4) @(posedge hclk);
    ack_go <= 1'b0;
    xfer(1'b1, IPSR_CTRL_STAT_OFS, 32'h00000000);
    rd(IPSR_CTRL_STAT_OFS, 32'h00000F7F, 32'h00000548);
    chk({28'h0, irq_lvl_r}, 32'h5);
    level_in <= 4'h7;
    xfer(1'b1, IPSR_USB_PRIO_OFS, 32'h00000700);
    rd(IPSR_CTRL_STAT_OFS, 32'hFFFFF0FF, 32'h00008048);
    report_and_stop;
  end
endmodule // intr_priority_status_regs_tb
